// ---- sbds_pkg.sv ----
// sbds_pkg: opcodes, flag layout, reset values and timing for the subtract/decrement datapath
// assumes a core decoder that presents one of these opcodes with its operand
`default_nettype none
package sbds_pkg;
    localparam int DATA_W = 8;
    typedef enum logic [1:0] {
        SBDS_OP_NONE = 2'h0,
        SBDS_OP_SUB_BORROW_TO_ACC = 2'h1,
        SBDS_OP_SUB_BORROW_TO_MEM = 2'h2,
        SBDS_OP_DEC_SKIP_IF_ZERO = 2'h3
    } sbds_op_type;
    typedef enum logic [1:0] {
        SBDS_ST_IDLE = 2'h0,
        SBDS_ST_EXEC = 2'h1,
        SBDS_ST_DUMMY = 2'h3
    } sbds_state_type;
    // flag vector bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_AUX = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVF = 3;
    localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [DATA_W-1:0] DEC_STEP = 8'h01;
    // dummy cycles inserted by a taken skip
    localparam int SKIP_DUMMY_CYCLES = 1;
endpackage : sbds_pkg
`default_nettype wire

// ---- sbds_datapath.sv ----
// sbds_datapath: execution of subtract-with-borrow (to accumulator or memory) and decrement-skip-if-zero
// assumes the decoder holds opStart for one cycle per instruction and waits while busy is high
`timescale 1ns/100ps
`default_nettype none
module sbds_datapath (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // instruction request
    input wire logic opStart,
    input wire sbds_pkg::sbds_op_type opCode,
    input wire logic [sbds_pkg::DATA_W-1:0] memOperand,
    input wire logic [7:0] memAddr,
    // data memory write-back
    output logic memWrite,
    output logic [7:0] memWriteAddr,
    output logic [sbds_pkg::DATA_W-1:0] memWriteData,
    // architectural state and sequencing
    output logic [sbds_pkg::DATA_W-1:0] accumulator_reg,
    output logic carry_flag,
    output logic aux_carry_flag,
    output logic zero_flag,
    output logic overflow_flag,
    output logic skipNext,
    output logic busy,
    output logic done
);
    import sbds_pkg::*;

    // dummy-cycle counter load; two bits cover up to three inserted cycles
    localparam logic [1:0] DUMMY_LOAD = 2'(SKIP_DUMMY_CYCLES);

    // sequencing state and the operands captured when an instruction is taken
    sbds_state_type state;
    sbds_state_type next_state;
    sbds_op_type curOp;
    logic [DATA_W-1:0] opnd;
    logic [7:0] addr;
    logic [1:0] dummyLeft;

    // instruction decode
    wire logic isSubAcc = (curOp == SBDS_OP_SUB_BORROW_TO_ACC);
    wire logic isSubMem = (curOp == SBDS_OP_SUB_BORROW_TO_MEM);
    wire logic isSub = isSubAcc || isSubMem;
    wire logic isDec = (curOp == SBDS_OP_DEC_SKIP_IF_ZERO);
    wire logic inIdle = (state == SBDS_ST_IDLE);
    wire logic execNow = (state == SBDS_ST_EXEC);
    wire logic inDummy = (state == SBDS_ST_DUMMY);
    // a request with no opcode, or one that arrives while busy, is dropped without trace
    wire logic takeOp = inIdle && opStart && (opCode != SBDS_OP_NONE);

    // borrow-in comes from the flag register, so back-to-back subtracts
    // chain through the carry that the previous one left behind
    wire logic borrowIn = ~carry_flag;
    wire logic [DATA_W:0] diffWide = {1'b0, accumulator_reg} - {1'b0, opnd} - {{DATA_W{1'b0}}, borrowIn};
    wire logic [DATA_W-1:0] diff = diffWide[DATA_W-1:0];
    wire logic noBorrow = ~diffWide[DATA_W];
    // low nibble difference gives the half borrow behind the aux carry
    wire logic [4:0] lowNib = {1'b0, accumulator_reg[3:0]} - {1'b0, opnd[3:0]} - {4'h0, borrowIn};
    wire logic noHalfBorrow = ~lowNib[4];
    // signed overflow: operands of unlike sign and a result whose sign left the minuend's
    wire logic ovf = (accumulator_reg[DATA_W-1] ^ opnd[DATA_W-1]) & (accumulator_reg[DATA_W-1] ^ diff[DATA_W-1]);
    wire logic diffZero = (diff == 8'h00);

    // decrement and skip test
    wire logic [DATA_W-1:0] decVal = opnd - DEC_STEP;
    wire logic decZero = (decVal == 8'h00);
    wire logic skipTaken = execNow && isDec && decZero;
    // also leaves on an empty counter, so a zero load cannot hang the sequencer
    wire logic lastDummy = inDummy && (dummyLeft <= 2'h1);

    // update strobes and next values of the registered outputs
    wire logic accUpdate = execNow && isSubAcc;
    wire logic flagUpdate = execNow && isSub;
    wire logic next_memWrite = execNow && (isSubMem || isDec);
    wire logic [DATA_W-1:0] next_memWriteData = isDec ? decVal : diff;
    wire logic next_skipNext = skipTaken;
    wire logic next_busy = (next_state != SBDS_ST_IDLE);
    wire logic next_done = !inIdle && (next_state == SBDS_ST_IDLE);

    always_comb begin
        next_state = state;
        unique case (state)
            SBDS_ST_IDLE: begin
                if (takeOp) begin
                    next_state = SBDS_ST_EXEC;
                end
            end
            SBDS_ST_EXEC: begin
                // a zero decrement costs extra instruction cycles
                if (skipTaken) begin
                    next_state = SBDS_ST_DUMMY;
                end else begin
                    next_state = SBDS_ST_IDLE;
                end
            end
            SBDS_ST_DUMMY: begin
                // stay until the last owed dummy cycle has passed
                if (lastDummy) begin
                    next_state = SBDS_ST_IDLE;
                end
            end
            default: begin
                next_state = SBDS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SBDS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // loaded as the skip is taken, counted down through the dummy state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dummyLeft <= 2'h0;
        end else if (skipTaken) begin
            dummyLeft <= DUMMY_LOAD;
        end else if (inDummy) begin
            dummyLeft <= dummyLeft - 2'h1;
        end
    end

    // operands latch only on a take, so a dropped request cannot disturb one in flight
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            curOp <= SBDS_OP_NONE;
            opnd <= 8'h00;
            addr <= 8'h00;
        end else if (takeOp) begin
            curOp <= opCode;
            opnd <= memOperand;
            addr <= memAddr;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_reg <= ACCUM_RESET;
        end else if (accUpdate) begin
            accumulator_reg <= diff;
        end
    end

    // flags only move on subtracts; the decrement path never touches them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            carry_flag <= FLAGS_RESET[FLAG_C];
        end else if (flagUpdate) begin
            carry_flag <= noBorrow;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_carry_flag <= FLAGS_RESET[FLAG_AUX];
        end else if (flagUpdate) begin
            aux_carry_flag <= noHalfBorrow;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_flag <= FLAGS_RESET[FLAG_Z];
        end else if (flagUpdate) begin
            zero_flag <= diffZero;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= FLAGS_RESET[FLAG_OVF];
        end else if (flagUpdate) begin
            overflow_flag <= ovf;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memWrite <= 1'b0;
        end else begin
            memWrite <= next_memWrite;
        end
    end

    // address and data load on every execute cycle, including accumulator subtracts that raise no memWrite
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memWriteAddr <= 8'h00;
        end else if (execNow) begin
            memWriteAddr <= addr;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memWriteData <= 8'h00;
        end else if (execNow) begin
            memWriteData <= next_memWriteData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            skipNext <= 1'b0;
        end else begin
            skipNext <= next_skipNext;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end
endmodule : sbds_datapath
`default_nettype wire

// ---- sbds_datapath_properties.sv ----
// port checker for sbds_datapath
// assumes it is bound to the datapath from the bench
`timescale 1ns/100ps
`default_nettype none
module sbds_datapath_properties
import sbds_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // instruction request
    input wire logic opStart,
    input wire sbds_pkg::sbds_op_type opCode,
    input wire logic [7:0] memOperand,
    // sequencing and results
    input wire logic busy,
    input wire logic done,
    input wire logic memWrite,
    input wire logic skipNext,
    input wire logic [7:0] memWriteData,
    input wire logic [7:0] accumulator_reg,
    input wire logic carry_flag,
    input wire logic aux_carry_flag,
    input wire logic zero_flag,
    input wire logic overflow_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // opcode accepted at this edge, none while the datapath is busy
    wire logic [1:0] tk = (opStart && !busy) ? opCode : 2'h0;
    wire logic [7:0] dif = accumulator_reg - memOperand - !carry_flag;
    wire logic nb = {1'b0, accumulator_reg} >= memOperand + !carry_flag;
    wire logic dz = memOperand == 8'h01;
    wire logic [3:0] fl = {carry_flag, aux_carry_flag, zero_flag, overflow_flag};
    property p_accum; $past(tk, 2) == SBDS_OP_SUB_BORROW_TO_ACC |-> accumulator_reg == $past(dif, 2); endproperty
    a_accum: assert property (p_accum) else $error("accumulator result");
    property p_zro; ^$past(tk, 2) |-> zero_flag == ($past(dif, 2) == 8'h00); endproperty
    a_zro: assert property (p_zro) else $error("zero flag");
    // codes 1 and 2 are the two subtracts, so odd parity picks them
    property p_cry; ^$past(tk, 2) |-> carry_flag == $past(nb, 2); endproperty
    a_cry: assert property (p_cry) else $error("carry");
    property p_mem; $past(tk, 2) == SBDS_OP_SUB_BORROW_TO_MEM |-> memWrite && memWriteData == $past(dif, 2)
        && accumulator_reg == $past(accumulator_reg, 2); endproperty
    a_mem: assert property (p_mem) else $error("mem result");
    property p_dec; $past(tk, 2) == SBDS_OP_DEC_SKIP_IF_ZERO |-> memWrite && memWriteData == $past(memOperand, 2) - 8'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement");
    property p_skp; $past(tk, 2) == SBDS_OP_DEC_SKIP_IF_ZERO && $past(dz, 2) |-> skipNext && busy && !done ##1 done;
    endproperty
    a_skp: assert property (p_skp) else $error("skip");
    property p_nsk; $past(tk, 2) == SBDS_OP_DEC_SKIP_IF_ZERO && !$past(dz, 2) |-> !skipNext && done; endproperty
    a_nsk: assert property (p_nsk) else $error("no skip");
    property p_flg; $past(tk, 2) == SBDS_OP_DEC_SKIP_IF_ZERO |-> fl == $past(fl, 2); endproperty
    a_flg: assert property (p_flg) else $error("flags moved");
endmodule : sbds_datapath_properties
`default_nettype wire

// ---- sbds_datapath_tb.sv ----
// bench for sbds_datapath: one task per scenario
// assumes the package and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_fail++; $display("BAD %s %0h %0h", nm, e, g); end end
module subtract_borrow_and_skip_decrement_tb;
    import sbds_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, opStart = 1'b0;
    sbds_op_type opCode = SBDS_OP_NONE;
    logic [7:0] memOperand = 8'h00, memAddr = 8'h00, memWriteAddr, memWriteData, accumulator_reg;
    logic memWrite, carry_flag, aux_carry_flag, zero_flag, overflow_flag, skipNext, busy, done;
    int n_fail = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    sbds_datapath uut (.clk, .rst_b, .opStart, .opCode, .memOperand, .memAddr, .memWrite, .memWriteAddr,
        .memWriteData, .accumulator_reg, .carry_flag, .aux_carry_flag, .zero_flag, .overflow_flag, .skipNext,
        .busy, .done);
    task automatic summarize;
        $display("compares %0d bad %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // returns in the done cycle, so the next call issues back to back
    task automatic run(input sbds_op_type op, input logic [7:0] m, input int cyc, input int nw, input int ns);
        int n, w, s;
        w = 0;
        s = 0;
        opCode = op;
        memOperand = m;
        memAddr = 8'h3C;
        opStart = 1'b1;
        @(posedge clk) #1 opStart = 1'b0;
        for (n = 1; n < 9; n++) begin
            w += memWrite;
            s += skipNext;
            if (done === 1'b1) break;
            @(posedge clk) #1;
        end
        if (n == 9) begin
            n_fail++;
            summarize();
        end
        `CHK("cycles", cyc, n)
        `CHK("writes", nw, w)
        `CHK("skips", ns, s)
    endtask : run
    // reset leaves the accumulator and flags at zero, and a request with no opcode is dropped
    task automatic t_refuse;
        int k, d;
        d = 0;
        `CHK("accum", 8'h00, accumulator_reg)
        `CHK("flags", 4'h0, {carry_flag, aux_carry_flag, zero_flag, overflow_flag})
        opCode = SBDS_OP_NONE;
        memOperand = 8'h55;
        opStart = 1'b1;
        @(posedge clk) #1 opStart = 1'b0;
        for (k = 0; k < 4; k++) begin
            d += done + memWrite + busy;
            @(posedge clk) #1;
        end
        `CHK("dropped", 0, d)
        `CHK("accum", 8'h00, accumulator_reg)
        $display("refuse test over");
    endtask : t_refuse
    task automatic t_accum;
        run(SBDS_OP_SUB_BORROW_TO_ACC, 8'h05, 2, 0, 0);
        `CHK("accum", 8'hFA, accumulator_reg)
        `CHK("c", 1'b0, carry_flag)
        `CHK("aux", 1'b0, aux_carry_flag)
        `CHK("z", 1'b0, zero_flag)
        run(SBDS_OP_SUB_BORROW_TO_ACC, 8'h10, 2, 0, 0);
        `CHK("accum", 8'hE9, accumulator_reg)
        `CHK("c", 1'b1, carry_flag)
        `CHK("aux", 1'b1, aux_carry_flag)
        run(SBDS_OP_SUB_BORROW_TO_ACC, 8'hE9, 2, 0, 0);
        `CHK("accum", 8'h00, accumulator_reg)
        `CHK("z", 1'b1, zero_flag)
        $display("accumulator test over");
    endtask : t_accum
    task automatic t_mem;
        run(SBDS_OP_SUB_BORROW_TO_MEM, 8'h80, 2, 1, 0);
        `CHK("wdata", 8'h80, memWriteData)
        `CHK("waddr", 8'h3C, memWriteAddr)
        `CHK("accum", 8'h00, accumulator_reg)
        `CHK("c", 1'b0, carry_flag)
        `CHK("overflow", 1'b1, overflow_flag)
        `CHK("aux", 1'b1, aux_carry_flag)
        $display("mem test over");
    endtask : t_mem
    task automatic t_dec;
        run(SBDS_OP_DEC_SKIP_IF_ZERO, 8'h01, 3, 1, 1);
        `CHK("wdata", 8'h00, memWriteData)
        `CHK("flags", 4'h5, {carry_flag, aux_carry_flag, zero_flag, overflow_flag})
        run(SBDS_OP_DEC_SKIP_IF_ZERO, 8'h00, 2, 1, 0);
        `CHK("wdata", 8'hFF, memWriteData)
        $display("dec test over");
    endtask : t_dec
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        @(posedge clk) #1;
        t_refuse();
        t_accum();
        t_mem();
        t_dec();
        summarize();
    end
endmodule : subtract_borrow_and_skip_decrement_tb
bind sbds_datapath sbds_datapath_properties chk (.clk, .rst_b, .opStart, .opCode, .memOperand, .busy, .done,
    .memWrite, .skipNext, .memWriteData, .accumulator_reg, .carry_flag, .aux_carry_flag, .zero_flag,
    .overflow_flag);
`default_nettype wire
